//--- design/buck_seq_pkg.sv
// constants, register map and state type of the buck start-up and protection sequencer
// assumes a 100 MHz system clock and a switching rate derived from it by a divider
package buck_seq_pkg;
   // clock and switching rate
   localparam int CLK_PERIOD_NS    = 10;
   localparam int CLK_FREQ_KHZ     = 100000;
   localparam int SW_FREQ_KHZ      = 600;
   localparam int SW_PERIOD_CYCLES = CLK_FREQ_KHZ / SW_FREQ_KHZ;
   // hiccup hold in switching cycles
   localparam int HICCUP_SW_CYCLES = 4096;
   // overcurrent blanking after the low-side gate rises, least time so round up
   localparam int OC_BLANK_NS      = 160;
   localparam int OC_BLANK_CYCLES  = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // pre-bias pulses per low-side step
   localparam logic [5:0] PREBIAS_PULSES_0 = 6'h20;
   localparam logic [5:0] PREBIAS_PULSES_1 = 6'h10;
   localparam logic [5:0] PREBIAS_PULSES_2 = 6'h08;
   localparam logic [1:0] STEP_FULL        = 2'h3;
   // register offsets (byte addresses)
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_MASK    = 8'h08;
   localparam logic [7:0] ADDR_STATE   = 8'h0c;
   // control fields and reset values
   localparam int         CTRL_RUN_BIT   = 0;
   localparam logic       CTRL_RUN_RESET = 1'b1;
   localparam logic [3:0] MASK_RESET     = 4'h0;
   // event bits shared by status and mask
   localparam int EV_W        = 4;
   localparam int EV_OC_TRIP  = 0;
   localparam int EV_UNDERVOLTAGE_LOCKOUT     = 1;
   localparam int EV_SS_OFF   = 2;
   localparam int EV_SS_CLAMP = 3;
   // state readback fields
   localparam int ST_POR_BIT   = 0;
   localparam int ST_STATE_LSB = 1;
   localparam int ST_STEP_LSB  = 4;
   localparam int ST_OC_BIT    = 6;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_SS,
      ST_SWITCH,
      ST_SS_OFF,
      ST_HICCUP
   } seq_state_t;
endpackage

//--- design/sync_2ff.sv
// two-stage synchroniser for a group of asynchronous comparator levels
// assumes each bit is a slow level; no bus coherence between bits
`timescale 1ns/10ps
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage read only by the second
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         q_out    <= '0;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule

//--- design/ls_step_sequencer.sv
// pre-bias low-side duty step counter: 25%, 50%, 75%, then full width
// assumes sw_tick is a one-cycle pulse per switching cycle
`timescale 1ns/10ps
module ls_step_sequencer (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clear,
   input  wire logic       sw_tick,
   input  wire logic       advance_en,
   output logic      [1:0] step,
   output logic            step_full
);
   logic [1:0] step_reg;
   logic [1:0] step_next;
   logic [5:0] count_reg;
   logic [5:0] count_next;
   logic [5:0] limit;

   // pulses per step and advance on each switching cycle
   always_comb begin
      step_next  = step_reg;
      count_next = count_reg;
      case (step_reg)
         2'h0:    limit = buck_seq_pkg::PREBIAS_PULSES_0;
         2'h1:    limit = buck_seq_pkg::PREBIAS_PULSES_1;
         default: limit = buck_seq_pkg::PREBIAS_PULSES_2;
      endcase
      if (clear) begin
         step_next  = 2'h0;
         count_next = 6'h00;
      end else if (advance_en && sw_tick && step_reg != buck_seq_pkg::STEP_FULL) begin
         if (count_reg == limit - 6'h01) begin
            step_next  = step_reg + 2'h1;
            count_next = 6'h00;
         end else begin
            count_next = count_reg + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         step_reg  <= 2'h0;
         count_reg <= 6'h00;
      end else begin
         step_reg  <= step_next;
         count_reg <= count_next;
      end
   end

   assign step      = step_reg;
   assign step_full = (step_reg == buck_seq_pkg::STEP_FULL);
endmodule

//--- design/buck_startup_protection_sequencer.sv
// start-up, shutdown and overcurrent hiccup sequencer of a synchronous buck controller
// assumes comparator results arrive asynchronously and a plain register port on clk_sys
//
// Summary of operation
// [RL1] Both gate drives stay off while bias or enable is below lockout.
// [RL2] Switching resumes only when bias and enable are both above threshold.
// [RL3] Power-on-ready needs all inputs valid and its rise starts soft start.
// [RL4] Turn-on waits for the enable comparator; enable doubles as logic enable.
// [RL5] Low side stays off until the first high-side pulse has occurred.
// [RL6] Low-side duty steps 25%, 50%, 75%, then full width.
// [RL7] Steps last 32, 16 and 8 switching cycles.
// [RL8] Power-on-ready turns on the soft-start charge source up to clamp.
// [RL9] Overcurrent detection stays active during soft start.
// [RL10] Enable below shutdown threshold places both drivers in high impedance.
// [RL11] Soft-start node pulled below shutdown level stops the output.
// [RL12] Outside party releases the soft-start node to restart the ramp.
// [RL13] Overcurrent flagged when sense goes below ground with low side on.
// [RL14] Overcurrent trip latches the flag and enters hiccup.
// [RL15] Hiccup grounds soft-start node for 4096 switching cycles.
// [RL16] Hiccup end clears flag, restarts soft start, repeats while overload stays.
// [RL17] Overcurrent sampling starts 160 ns after the low-side gate rises.
// [RL18] Hiccup and step counters tick per switching cycle, clear without ready.
// [RL19] Ready low turns drives off, returns to idle and discharges soft start.
`timescale 1ns/10ps
module buck_startup_protection_sequencer #(
   parameter int SW_PERIOD     = buck_seq_pkg::SW_PERIOD_CYCLES,
   parameter int HICCUP_CYCLES = buck_seq_pkg::HICCUP_SW_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        bias_above_undervoltage_lockout,
   input  wire logic        enable_above_undervoltage_lockout,
   input  wire logic        ss_above_shutdown,
   input  wire logic        ss_at_clamp,
   input  wire logic        sense_below_ground,
   input  wire logic        pwm_high_req,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_strobe,
   input  wire logic        rd_strobe,
   output logic      [31:0] rdata,
   output logic             power_on_ready,
   output logic             driver_oe,
   output logic             hs_gate_en,
   output logic             ls_gate_en,
   output logic             ss_charge_en,
   output logic             ss_discharge_en,
   output logic             overcurrent_trip_flag,
   output logic             irq
);
   // synchronised comparator levels
   logic [5:0] pins_s;
   logic       bias_s;
   logic       enable_s;
   logic       ss_ok_s;
   logic       clamp_s;
   logic       sense_s;
   logic       hs_req_s;

   sync_2ff #(
      .WIDTH (6)
   ) u_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .d_in    ({pwm_high_req, sense_below_ground, ss_at_clamp, ss_above_shutdown,
                 enable_above_undervoltage_lockout, bias_above_undervoltage_lockout}),
      .q_out   (pins_s)
   );

   assign bias_s   = pins_s[0];
   assign enable_s = pins_s[1];
   assign ss_ok_s  = pins_s[2];
   assign clamp_s  = pins_s[3];
   assign sense_s  = pins_s[4];
   assign hs_req_s = pins_s[5];

   // switching-cycle divider
   logic [15:0] phase_reg;
   logic [15:0] phase_next;
   logic        sw_tick;

   always_comb begin
      sw_tick    = (phase_reg == 16'(SW_PERIOD - 1));
      phase_next = sw_tick ? 16'h0000 : phase_reg + 16'h0001;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= 16'h0000;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // register file state
   logic                         ctrl_run_reg;
   logic                         ctrl_run_next;
   logic [buck_seq_pkg::EV_W-1:0] status_reg;
   logic [buck_seq_pkg::EV_W-1:0] status_next;
   logic [buck_seq_pkg::EV_W-1:0] mask_reg;
   logic [buck_seq_pkg::EV_W-1:0] mask_next;
   logic [buck_seq_pkg::EV_W-1:0] events;
   logic [31:0]                   rdata_next;
   logic                          irq_next;
   logic                          clamp_prev_reg;

   // sequencer state
   buck_seq_pkg::seq_state_t state_reg;
   buck_seq_pkg::seq_state_t state_next;
   logic [15:0]              hiccup_reg;
   logic [15:0]              hiccup_next;
   logic                     oc_flag_next;
   logic                     por_next;
   logic                     oc_trip;
   logic [15:0]              blank_reg;
   logic [15:0]              blank_next;

   // power-on-ready from bias, enable and software run bit
   // [RL4] enable gates turn-on
   // [RL3] all inputs valid
   always_comb begin
      por_next = bias_s && enable_s && ctrl_run_reg;
   end

   // [RL17] blanking after low-side rise
   always_comb begin
      if (!ls_gate_en) begin
         blank_next = 16'h0000;
      end else if (blank_reg < 16'(buck_seq_pkg::OC_BLANK_CYCLES)) begin
         blank_next = blank_reg + 16'h0001;
      end else begin
         blank_next = blank_reg;
      end
   end

   // [RL13] sense below ground, low side on
   assign oc_trip = sense_s && ls_gate_en && (blank_reg >= 16'(buck_seq_pkg::OC_BLANK_CYCLES));

   // main sequence, hiccup count and latched overcurrent flag
   always_comb begin
      state_next   = state_reg;
      hiccup_next  = hiccup_reg;
      oc_flag_next = overcurrent_trip_flag;
      case (state_reg)
         buck_seq_pkg::ST_IDLE: begin
            // [RL3] ready starts soft start
            if (por_next) begin
               state_next = buck_seq_pkg::ST_WAIT_SS;
            end
         end
         buck_seq_pkg::ST_WAIT_SS: begin
            if (ss_ok_s) begin
               state_next = buck_seq_pkg::ST_SWITCH;
            end
         end
         buck_seq_pkg::ST_SWITCH: begin
            // [RL9] trip checked during ramp
            // [RL14] latch and enter hiccup
            if (oc_trip) begin
               state_next   = buck_seq_pkg::ST_HICCUP;
               oc_flag_next = 1'b1;
               hiccup_next  = 16'h0000;
            end else if (!ss_ok_s) begin
               // [RL11] node pulled low
               state_next = buck_seq_pkg::ST_SS_OFF;
            end
         end
         buck_seq_pkg::ST_SS_OFF: begin
            // [RL12] node released restarts ramp
            if (ss_ok_s) begin
               state_next = buck_seq_pkg::ST_WAIT_SS;
            end
         end
         buck_seq_pkg::ST_HICCUP: begin
            // [RL15] count switching cycles
            // [RL16] clear flag, restart soft start
            if (sw_tick) begin
               if (hiccup_reg == 16'(HICCUP_CYCLES - 1)) begin
                  state_next   = buck_seq_pkg::ST_WAIT_SS;
                  oc_flag_next = 1'b0;
                  hiccup_next  = 16'h0000;
               end else begin
                  hiccup_next = hiccup_reg + 16'h0001;
               end
            end
         end
         default: begin
            state_next = buck_seq_pkg::ST_IDLE;
         end
      endcase
      // [RL19] ready low returns to idle
      // [RL18] counters cleared
      if (!por_next) begin
         state_next   = buck_seq_pkg::ST_IDLE;
         hiccup_next  = 16'h0000;
         oc_flag_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg             <= buck_seq_pkg::ST_IDLE;
         hiccup_reg            <= 16'h0000;
         overcurrent_trip_flag <= 1'b0;
         power_on_ready        <= 1'b0;
         blank_reg             <= 16'h0000;
      end else begin
         state_reg             <= state_next;
         hiccup_reg            <= hiccup_next;
         overcurrent_trip_flag <= oc_flag_next;
         power_on_ready        <= por_next;
         blank_reg             <= blank_next;
      end
   end

   // pre-bias step counter
   logic [1:0] step;
   logic       step_full;
   logic       switching;
   logic       first_hs_reg;
   logic       first_hs_next;

   assign switching = (state_next == buck_seq_pkg::ST_SWITCH);

   // [RL7] 32, 16, 8 cycles per step
   // [RL18] cleared outside switching
   ls_step_sequencer u_steps (
      .clk_sys    (clk_sys),
      .nrst       (nrst),
      .clear      (!switching),
      .sw_tick    (sw_tick),
      .advance_en (first_hs_reg),
      .step       (step),
      .step_full  (step_full)
   );

   // gate drive group
   logic        hs_next;
   logic        ls_next;
   logic [15:0] ls_cnt_reg;
   logic [15:0] ls_cnt_next;
   logic [15:0] ls_limit;
   logic        oe_next;
   logic        charge_next;
   logic        discharge_next;

   always_comb begin
      // [RL6] low-side width in quarters of the period
      ls_limit      = 16'((SW_PERIOD * (int'(step) + 1)) / 4);
      // [RL1] [RL2] drives only while switching
      hs_next       = switching && hs_req_s;
      first_hs_next = first_hs_reg;
      if (!switching) begin
         first_hs_next = 1'b0;
      end else if (hs_gate_en) begin
         first_hs_next = 1'b1;
      end
      // [RL5] low side waits for first high-side pulse
      ls_next = switching && first_hs_reg && !hs_req_s && !hs_gate_en
                && (step_full || ls_cnt_reg < ls_limit);
      if (sw_tick || hs_next) begin
         ls_cnt_next = 16'h0000;
      end else if (ls_next) begin
         ls_cnt_next = ls_cnt_reg + 16'h0001;
      end else begin
         ls_cnt_next = ls_cnt_reg;
      end
      // [RL10] drivers tristated without ready
      oe_next        = por_next;
      // [RL8] charge source on from ready
      charge_next    = (state_next == buck_seq_pkg::ST_WAIT_SS) || (state_next == buck_seq_pkg::ST_SWITCH)
                       || (state_next == buck_seq_pkg::ST_SS_OFF);
      // [RL15] [RL19] node grounded in hiccup and idle
      discharge_next = (state_next == buck_seq_pkg::ST_HICCUP) || (state_next == buck_seq_pkg::ST_IDLE);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hs_gate_en      <= 1'b0;
         ls_gate_en      <= 1'b0;
         first_hs_reg    <= 1'b0;
         ls_cnt_reg      <= 16'h0000;
         driver_oe       <= 1'b0;
         ss_charge_en    <= 1'b0;
         ss_discharge_en <= 1'b1;
      end else begin
         hs_gate_en      <= hs_next;
         ls_gate_en      <= ls_next;
         first_hs_reg    <= first_hs_next;
         ls_cnt_reg      <= ls_cnt_next;
         driver_oe       <= oe_next;
         ss_charge_en    <= charge_next;
         ss_discharge_en <= discharge_next;
      end
   end

   // events, sticky status with write-one-to-clear, mask, register port
   always_comb begin
      events = '0;
      events[buck_seq_pkg::EV_OC_TRIP]  = (state_reg == buck_seq_pkg::ST_SWITCH) && oc_trip;
      events[buck_seq_pkg::EV_UNDERVOLTAGE_LOCKOUT]     = power_on_ready && !por_next;
      events[buck_seq_pkg::EV_SS_OFF]   = (state_reg == buck_seq_pkg::ST_SWITCH)
                                          && (state_next == buck_seq_pkg::ST_SS_OFF);
      events[buck_seq_pkg::EV_SS_CLAMP] = clamp_s && !clamp_prev_reg;
      ctrl_run_next = ctrl_run_reg;
      mask_next     = mask_reg;
      status_next   = status_reg;
      if (wr_strobe && addr == buck_seq_pkg::ADDR_CONTROL) begin
         ctrl_run_next = wdata[buck_seq_pkg::CTRL_RUN_BIT];
      end
      if (wr_strobe && addr == buck_seq_pkg::ADDR_MASK) begin
         mask_next = wdata[buck_seq_pkg::EV_W-1:0];
      end
      if (wr_strobe && addr == buck_seq_pkg::ADDR_STATUS) begin
         status_next = status_reg & ~wdata[buck_seq_pkg::EV_W-1:0];
      end
      status_next = status_next | events; // set wins over clear
      irq_next    = |(status_next & mask_next);
      rdata_next  = 32'h0000_0000;
      if (rd_strobe) begin
         case (addr)
            buck_seq_pkg::ADDR_CONTROL: rdata_next[buck_seq_pkg::CTRL_RUN_BIT] = ctrl_run_reg;
            buck_seq_pkg::ADDR_STATUS:  rdata_next[buck_seq_pkg::EV_W-1:0] = status_reg;
            buck_seq_pkg::ADDR_MASK:    rdata_next[buck_seq_pkg::EV_W-1:0] = mask_reg;
            buck_seq_pkg::ADDR_STATE: begin
               rdata_next[buck_seq_pkg::ST_POR_BIT]                               = power_on_ready;
               rdata_next[buck_seq_pkg::ST_STATE_LSB+2:buck_seq_pkg::ST_STATE_LSB] = state_reg;
               rdata_next[buck_seq_pkg::ST_STEP_LSB+1:buck_seq_pkg::ST_STEP_LSB]   = step;
               rdata_next[buck_seq_pkg::ST_OC_BIT]                                = overcurrent_trip_flag;
            end
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_run_reg   <= buck_seq_pkg::CTRL_RUN_RESET;
         mask_reg       <= buck_seq_pkg::MASK_RESET;
         status_reg     <= '0;
         irq            <= 1'b0;
         rdata          <= 32'h0000_0000;
         clamp_prev_reg <= 1'b0;
      end else begin
         ctrl_run_reg   <= ctrl_run_next;
         mask_reg       <= mask_next;
         status_reg     <= status_next;
         irq            <= irq_next;
         rdata          <= rdata_next;
         clamp_prev_reg <= clamp_s;
      end
   end

   // checks on sequencing and protection
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_undervoltage_lockout_drives_off: assert property (!power_on_ready |-> !hs_gate_en && !ls_gate_en) // RL1
      else $error("gate drive on without ready");
   a_resume_needs_both: assert property ($rose(hs_gate_en) |-> $past(bias_s) && $past(enable_s)) // RL2
      else $error("switching resumed with an input low");
   a_ready_starts_ss: assert property ($rose(power_on_ready) |=> state_reg == buck_seq_pkg::ST_WAIT_SS) // RL3
      else $error("ready did not start soft start");
   a_enable_gates_on: assert property (!enable_s |=> !power_on_ready) // RL4
      else $error("ready with enable low");
   a_ls_after_hs: assert property (ls_gate_en |-> first_hs_reg && !hs_gate_en) // RL5
      else $error("low side before first high-side pulse");
   a_ls_step_width: assert property (ls_gate_en && !step_full |-> ls_cnt_reg <= ls_limit) // RL6
      else $error("low-side pulse wider than step");
   a_step_needs_pulses: assert property ($changed(step) && step != 2'h0 |-> $past(sw_tick)) // RL7
      else $error("step advanced off a switching tick");
   a_ss_charges: assert property (state_reg == buck_seq_pkg::ST_SWITCH |-> ss_charge_en && !ss_discharge_en) // RL8
      else $error("soft start not charging while switching");
   a_tristate_off: assert property (!enable_s |=> !driver_oe) // RL10
      else $error("drivers not tristated");
   a_ss_pull_off: assert property (state_reg == buck_seq_pkg::ST_SWITCH && !ss_ok_s && !oc_trip
                                   && por_next |=> !hs_gate_en && !ls_gate_en) // RL11
      else $error("output not stopped on soft-start pull-down");
   a_oc_blanked: assert property ($rose(overcurrent_trip_flag) |-> $past(ls_gate_en)
                                  && $past(blank_reg) >= 16'(buck_seq_pkg::OC_BLANK_CYCLES)) // RL17
      else $error("overcurrent sampled inside blanking");
   a_oc_to_hiccup: assert property (events[buck_seq_pkg::EV_OC_TRIP] && por_next
                                    |=> overcurrent_trip_flag && state_reg == buck_seq_pkg::ST_HICCUP) // RL14
      else $error("trip did not latch into hiccup");
   a_hiccup_grounds: assert property (state_reg == buck_seq_pkg::ST_HICCUP |-> ss_discharge_en && !ss_charge_en) // RL15
      else $error("soft-start node not held low in hiccup");
   a_hiccup_exit: assert property ($fell(overcurrent_trip_flag) && power_on_ready
                                   |-> state_reg == buck_seq_pkg::ST_WAIT_SS && $past(sw_tick)) // RL16
      else $error("hiccup exit out of sequence");
   a_idle_on_drop: assert property (!power_on_ready |-> state_reg == buck_seq_pkg::ST_IDLE
                                    && hiccup_reg == 16'h0000 && ss_discharge_en) // RL19
      else $error("not idle without ready");

   c_hiccup_entry: cover property (state_reg == buck_seq_pkg::ST_SWITCH ##1 state_reg == buck_seq_pkg::ST_HICCUP);
   c_ss_pulled: cover property (state_reg == buck_seq_pkg::ST_SS_OFF ##1 state_reg == buck_seq_pkg::ST_WAIT_SS);
   c_full_width: cover property (step_full && ls_gate_en);
   c_irq_raised: cover property ($rose(irq));
endmodule

//--- verif/gate_drive_model.sv
// gate-drive and soft-start node model on the far side of the sequencer
// assumes registered enables from the sequencer on the one system clock
`timescale 1ns/10ps
module gate_drive_model (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic ls_gate_en,
   input  wire logic driver_oe,
   input  wire logic ss_charge_en,
   input  wire logic ss_discharge_en,
   input  wire logic overload,
   input  wire logic ss_pull_low,
   output logic      sense_below_ground,
   output logic      ss_above_shutdown,
   output logic      ss_at_clamp
);
   logic [5:0] ss_lvl;
   // sense below ground only while low side conducts
   assign sense_below_ground = overload & ls_gate_en & driver_oe;
   // node charges, is shorted or pulled low
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) ss_lvl <= 6'h00;
      else if (ss_discharge_en | ss_pull_low) ss_lvl <= 6'h00;
      else if (ss_charge_en && ss_lvl != 6'h3f) ss_lvl <= ss_lvl + 6'h01;
   end
   // shutdown level near a tenth of the clamp
   assign ss_above_shutdown = (ss_lvl >= 6'h06);
   assign ss_at_clamp       = (ss_lvl == 6'h3f);
endmodule

//--- verif/tb.sv
// register-port sequences for start-up, pre-bias steps, hiccup and shutdown
// assumes the gate-drive model and a 32-clock switching period
`timescale 1ns/10ps
module tb;
   logic        clk_sys = 0, nrst = 0, bias = 0, enable = 0, overload = 0, pull = 0;
   logic        ss_above, ss_clamp, sense, pwm = 0, wr = 0, rd = 0;
   logic        por, oe, hs, ls, chg, dis, ocf, irq, hs_seen = 0, ls_early = 0;
   logic [7:0]  addr = 8'h00, mon;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [4:0]  ph = 5'h00;
   int          fails = 0, checks = 0, n;
   buck_startup_protection_sequencer #(.SW_PERIOD(32), .HICCUP_CYCLES(4)) uut (
      .clk_sys(clk_sys), .nrst(nrst), .bias_above_undervoltage_lockout(bias), .enable_above_undervoltage_lockout(enable),
      .ss_above_shutdown(ss_above), .ss_at_clamp(ss_clamp), .sense_below_ground(sense),
      .pwm_high_req(pwm), .addr(addr), .wdata(wdata), .wr_strobe(wr), .rd_strobe(rd), .rdata(rdata),
      .power_on_ready(por), .driver_oe(oe), .hs_gate_en(hs), .ls_gate_en(ls), .ss_charge_en(chg),
      .ss_discharge_en(dis), .overcurrent_trip_flag(ocf), .irq(irq));
   gate_drive_model drv (
      .clk_sys(clk_sys), .nrst(nrst), .ls_gate_en(ls), .driver_oe(oe), .ss_charge_en(chg),
      .ss_discharge_en(dis), .overload(overload), .ss_pull_low(pull), .sense_below_ground(sense),
      .ss_above_shutdown(ss_above), .ss_at_clamp(ss_clamp));
   // monitored outputs by bit index
   assign mon = {dis, ocf, hs, ls, oe, por, chg, irq};
   always #5 clk_sys = ~clk_sys;
   // pwm request in first 4 clocks of each period; low side seen before high side
   always @(posedge clk_sys) begin
      ph <= ph + 5'h01;
      pwm <= (ph < 5'h04);
      hs_seen <= por & (hs_seen | hs);
      if (ls && !hs_seen) ls_early <= 1'b1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      d = rdata;
   endtask
   // bounded wait for a monitored output to reach a level
   task automatic wait_for(input int b, input logic v, input int lim);
      n = 0;
      while (mon[b] !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      if (mon[b] !== v) begin
         fails++;
         $display("FAIL at %0t: wait on output %0d ran out", $time, b);
         end_of_test();
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      check(mon, 8'h80);
      nrst <= 1'b1;
      rd_reg(8'h00);
      check(d, 32'h1);
      rd_reg(8'h08);
      check(d, 32'h0);
      rd_reg(8'h10);
      check(d, 32'h0);
      enable <= 1'b1;
      repeat (10) @(posedge clk_sys);
      check({por, oe, hs, ls}, 4'h0);
      bias <= 1'b1;
      wait_for(2, 1'b1, 10);
      check(chg, 1'b1);
      $display("test lockout done");
      wait_for(5, 1'b1, 300);
      for (int i = 0; i < 4; i++) begin
         repeat ((i < 2 ? 20 : 12) * 32) @(posedge clk_sys);
         rd_reg(8'h0c);
         check({d[5:4], d[3:1]}, {i[1:0], 3'h2});
      end
      check(ls_early, 1'b0);
      $display("test pre-bias steps done");
      overload <= 1'b1;
      wait_for(6, 1'b1, 200);
      check({hs, ls, chg, dis}, 4'h1);
      repeat (3) @(posedge clk_sys);
      check(irq, 1'b0);
      n = 0;
      while (ocf === 1'b1 && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      // hold is 3 whole periods plus 1..32 clocks, 3 clocks already gone
      check(n >= 94 && n <= 125, 1'b1);
      check({ocf, chg}, 2'b01);
      wait_for(6, 1'b1, 3000);
      overload <= 1'b0;
      wait_for(6, 1'b0, 300);
      wr_reg(8'h08, 32'h1);
      repeat (3) @(posedge clk_sys);
      check(irq, 1'b1);
      wr_reg(8'h04, 32'h1);
      repeat (3) @(posedge clk_sys);
      check(irq, 1'b0);
      rd_reg(8'h04);
      check(d, 32'h8);
      $display("test hiccup done");
      wait_for(5, 1'b1, 3000);
      pull <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check({hs, ls}, 2'b00);
      rd_reg(8'h0c);
      check(d[3:1], 3'h3);
      pull <= 1'b0;
      wait_for(5, 1'b1, 300);
      $display("test soft-start shutdown done");
      enable <= 1'b0;
      wait_for(3, 1'b0, 10);
      check({por, hs, ls, dis}, 4'h1);
      enable <= 1'b1;
      wait_for(2, 1'b1, 10);
      $display("test enable shutdown done");
      end_of_test();
   end
endmodule
